// ==== core/pll_ctl_regs.vh ====
// Register map, field layout, reset values and timing counts of the PLL clock control
`ifndef PLL_CTL_REGS_VH
`define PLL_CTL_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_DIVS 8'h04
`define OFS_CLKDIV 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RATIO 8'h10

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_PLL_EN 0
`define CTRL_SEL_PLL 1
`define CTRL_DEEP 2
`define CTRL_RESET 3'h0

// ----------------------------------------
// Divider register fields
// ----------------------------------------
`define DIV_PRE_LSB 0
`define DIV_PRE_MSB 4
`define DIV_MUL_LSB 8
`define DIV_MUL_MSB 16
`define DIV_POST_LSB 24
`define DIV_POST_MSB 28
`define DIV_PRE_RESET 5'h00
`define DIV_MUL_RESET 9'h030
`define DIV_POST_RESET 5'h01
`define FIELD_OFFSET 2

// ----------------------------------------
// Peripheral clock divider fields
// ----------------------------------------
`define CLKDIV_BUS_LSB 0
`define CLKDIV_BUS_MSB 3
`define CLKDIV_AUX_LSB 8
`define CLKDIV_AUX_MSB 11

// ----------------------------------------
// Timing
// ----------------------------------------
`define REF_FREQ_MHZ 4
`define LOCK_TIME_US 500
`define LOCK_REF_EDGES (`LOCK_TIME_US * `REF_FREQ_MHZ)
`define SWITCH_GAP 3

`endif

// ==== core/pll_clock_control_sleep.v ====
// PLL divider control, lock timer, glitch-free core clock select and sleep gating
//
// Function
// - PLL reference is only the trimmed 4 MHz reference oscillator.
// - Output frequency is input times multiplier over pre, post and two.
// - Effective pre-divider spans 2 to 33.
// - Effective loop multiplier spans 2 to 513.
// - Post-divider field spans 0 to 31, then a further divide by two.
// - Multiplier and pre-divider fields hold value minus two.
// - Post-divider field is used directly, with extra factor two.
// - Output withheld until 500 us after divider programming.
// - Select-PLL command moves core source clock to the PLL.
// - Divider fields are never range-checked.
// - PLL disable stops the PLL at once, no handshake.
// - Ordinary sleep halts only the processor; any enabled interrupt wakes.
// - Deep sleep gates aux, bus and part of core source clocks.
// - Only timer, watchdog and GPIO wake from deep sleep.
// - Timer, watchdog or GPIO wake ungates clocks, then interrupts the processor.
// - Core source mux picks root clock or PLL output.
// - Bus and aux clocks come from separately programmable dividers.

`default_nettype none
`include "pll_ctl_regs.vh"

module pll_clock_control_sleep (
  // Clock and reset
  input wire CLK,
  input wire SRST,
  // AHB-Lite slave
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  // Reference oscillator, sampled level
  input wire TRIMMED_REFERENCE_OSC,
  // Analog loop controls
  output reg PLL_RUN,
  output reg [4:0] PRE_DIVIDER,
  output reg [8:0] LOOP_MULTIPLIER,
  output reg [4:0] POST_DIVIDER,
  // Core source clock gates
  output reg ROOT_CLK_EN,
  output reg MULTIPLIED_CLOCK_NET_EN,
  output reg CORE_GATE_EN,
  // Derived clock enables
  output reg BUS_CLK_TICK,
  output reg AUX_CLK_TICK,
  // Sleep control
  input wire SLEEP_REQ,
  input wire IRQ_PENDING,
  input wire RTC_WAKE,
  input wire WDT_WAKE,
  input wire GPIO_WAKE,
  output reg CPU_HALT,
  output reg WAKE_IRQ,
  // Status
  output reg LOCK_DONE
);

  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_SLEEP = 4'h2;
  localparam [3:0] ST_DEEP = 4'h4;
  localparam [3:0] ST_WAKE = 4'h8;

  // ----------------------------------------
  // Count end points
  // ----------------------------------------
  // Full-width forms, cut to the counter widths on purpose below
  localparam [31:0] LOCK_LAST_FULL = `LOCK_REF_EDGES - 1;
  localparam [31:0] GAP_LAST_FULL = `SWITCH_GAP - 1;
  // Last lock count before the lock-done flag; fits 11 bits
  localparam [10:0] LOCK_LAST = LOCK_LAST_FULL[10:0];
  // Last gap count of a break-before-make switch
  localparam [1:0] GAP_LAST = GAP_LAST_FULL[1:0];

  // ----------------------------------------
  // Registers and nets
  // ----------------------------------------
  // Control bits and peripheral divider settings
  reg [2:0] ctrl_reg;
  reg [3:0] bus_div_reg;
  reg [3:0] aux_div_reg;
  // Address phase held for the data phase
  reg ph_wr_reg;
  reg [7:0] ph_addr_reg;
  // Reference edge detector and lock counter
  reg ref_d_reg;
  reg [10:0] lock_cnt_reg;
  // Core source mux state
  reg on_pll_reg;
  reg switching_reg;
  reg [1:0] gap_reg;
  // Derived clock counters
  reg [3:0] bus_cnt_reg;
  reg [3:0] aux_cnt_reg;
  // Sleep state machine
  reg [3:0] state_reg;
  reg [3:0] state_next;
  // Bus decode
  wire addr_phase;
  wire wr_ctrl;
  wire wr_divs;
  wire [2:0] ctrl_next;
  // Lock, mux and wake conditions
  wire restart_lock;
  wire ref_rise;
  wire want_pll;
  wire deep_wake;
  // Frequency ratio readback
  wire [31:0] ratio_full;
  wire [11:0] ratio_num;
  wire [10:0] ratio_den;
  wire [6:0] pre_eff;
  wire [5:0] post_x2;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Zero-wait slave: every transfer completes at once with OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  // Taken only when selected, ready and NONSEQ or SEQ
  assign addr_phase = HSEL & HREADY & HTRANS[1];
  // Data phase decode from the held address
  assign wr_ctrl = ph_wr_reg & (ph_addr_reg == `OFS_CTRL);
  assign wr_divs = ph_wr_reg & (ph_addr_reg == `OFS_DIVS);
  // Control value as it stands after this edge, so a read or a disable
  // right behind a control write already sees the new bits
  assign ctrl_next = wr_ctrl ? HWDATA[2:0] : ctrl_reg;

  // Address phase capture
  always @(posedge CLK) begin
    if (SRST) begin
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else begin
      ph_wr_reg <= addr_phase & HWRITE;
      ph_addr_reg <= HADDR;
    end
  end

  // Register writes in the data phase; fields stored unchecked
  always @(posedge CLK) begin
    if (SRST) begin
      ctrl_reg <= `CTRL_RESET;
      PRE_DIVIDER <= `DIV_PRE_RESET;
      LOOP_MULTIPLIER <= `DIV_MUL_RESET;
      POST_DIVIDER <= `DIV_POST_RESET;
      bus_div_reg <= 4'h0;
      aux_div_reg <= 4'h0;
    end else if (ph_wr_reg) begin
      if (wr_ctrl)
        ctrl_reg <= HWDATA[2:0];
      if (wr_divs) begin
        PRE_DIVIDER <= HWDATA[`DIV_PRE_MSB:`DIV_PRE_LSB];
        LOOP_MULTIPLIER <= HWDATA[`DIV_MUL_MSB:`DIV_MUL_LSB];
        POST_DIVIDER <= HWDATA[`DIV_POST_MSB:`DIV_POST_LSB];
      end
      if (ph_addr_reg == `OFS_CLKDIV) begin
        bus_div_reg <= HWDATA[`CLKDIV_BUS_MSB:`CLKDIV_BUS_LSB];
        aux_div_reg <= HWDATA[`CLKDIV_AUX_MSB:`CLKDIV_AUX_LSB];
      end
    end
  end

  // Frequency ratio: fields offset by two, post doubled
  assign pre_eff = {2'b00, PRE_DIVIDER} + 7'd`FIELD_OFFSET;
  assign ratio_full = `REF_FREQ_MHZ * ({23'h000000, LOOP_MULTIPLIER} + 32'd`FIELD_OFFSET);
  assign ratio_num = ratio_full[11:0]; // At most 4 * 513, fits 12 bits
  assign post_x2 = {POST_DIVIDER, 1'b0};
  assign ratio_den = pre_eff * post_x2;

  // Read data registered in the address phase
  always @(posedge CLK) begin
    if (SRST) begin
      HRDATA <= 32'h00000000;
    end else if (addr_phase & ~HWRITE) begin
      case (HADDR)
        `OFS_CTRL: HRDATA <= {29'h0, ctrl_next};
        `OFS_DIVS: HRDATA <= {3'h0, POST_DIVIDER, 7'h0, LOOP_MULTIPLIER, 3'h0, PRE_DIVIDER};
        `OFS_CLKDIV: HRDATA <= {20'h0, aux_div_reg, 4'h0, bus_div_reg};
        `OFS_STATUS: HRDATA <= {28'h0, PLL_RUN, state_reg[2], on_pll_reg, LOCK_DONE};
        `OFS_RATIO: HRDATA <= {5'h0, ratio_den, 4'h0, ratio_num};
        // Unmapped offsets read as zero
        default: HRDATA <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // PLL enable and lock timer
  // ----------------------------------------
  // Only the trimmed reference feeds the lock timer
  assign ref_rise = TRIMMED_REFERENCE_OSC & ~ref_d_reg;
  // Any divider write or a fresh enable makes the loop relock
  assign restart_lock = wr_divs | (wr_ctrl & HWDATA[`CTRL_PLL_EN] & ~ctrl_reg[`CTRL_PLL_EN]);

  // Reference edge detector
  always @(posedge CLK) begin
    if (SRST)
      ref_d_reg <= 1'b0;
    else
      ref_d_reg <= TRIMMED_REFERENCE_OSC;
  end

  // Run follows the enable bit at once; lock counts reference edges
  always @(posedge CLK) begin
    if (SRST) begin
      PLL_RUN <= 1'b0;
      lock_cnt_reg <= 11'h000;
      LOCK_DONE <= 1'b0;
    end else begin
      PLL_RUN <= ctrl_next[`CTRL_PLL_EN];
      // Restart beats completion in the same cycle: the old count is stale
      if (~ctrl_next[`CTRL_PLL_EN] | restart_lock) begin
        lock_cnt_reg <= 11'h000;
        LOCK_DONE <= 1'b0;
      end else if (ref_rise & ~LOCK_DONE) begin
        if (lock_cnt_reg == LOCK_LAST)
          LOCK_DONE <= 1'b1;
        else
          lock_cnt_reg <= lock_cnt_reg + 11'h001;
      end
    end
  end

  // ----------------------------------------
  // Core source clock mux
  // ----------------------------------------
  // Select takes effect only once the loop runs and is locked
  assign want_pll = ctrl_reg[`CTRL_SEL_PLL] & LOCK_DONE & PLL_RUN;

  // Break before make: both gates low for a gap, then the new one
  always @(posedge CLK) begin
    if (SRST) begin
      on_pll_reg <= 1'b0;
      switching_reg <= 1'b0;
      gap_reg <= 2'h0;
      ROOT_CLK_EN <= 1'b1;
      MULTIPLIED_CLOCK_NET_EN <= 1'b0;
    end else if (~PLL_RUN & on_pll_reg) begin
      // Loop stopped under the mux: drop the multiplied path at once
      on_pll_reg <= 1'b0;
      MULTIPLIED_CLOCK_NET_EN <= 1'b0;
      switching_reg <= 1'b1;
      gap_reg <= 2'h0;
    end else if (switching_reg) begin
      // Both paths stay off until the gap has run out
      if (gap_reg == GAP_LAST) begin
        switching_reg <= 1'b0;
        ROOT_CLK_EN <= ~on_pll_reg;
        MULTIPLIED_CLOCK_NET_EN <= on_pll_reg;
      end else begin
        gap_reg <= gap_reg + 2'h1;
      end
    end else if (want_pll != on_pll_reg) begin
      on_pll_reg <= want_pll;
      switching_reg <= 1'b1;
      gap_reg <= 2'h0;
      ROOT_CLK_EN <= 1'b0;
      MULTIPLIED_CLOCK_NET_EN <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sleep control
  // ----------------------------------------
  // Sources that keep a clock through deep sleep
  assign deep_wake = RTC_WAKE | WDT_WAKE | GPIO_WAKE;

  // Next sleep state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (SLEEP_REQ)
          state_next = ctrl_reg[`CTRL_DEEP] ? ST_DEEP : ST_SLEEP;
      ST_SLEEP:
        if (IRQ_PENDING | deep_wake)
          state_next = ST_RUN;
      // Deep sleep ignores ordinary interrupts
      ST_DEEP:
        if (deep_wake)
          state_next = ST_WAKE;
      // One cycle in WAKE lets the clocks settle before the interrupt
      ST_WAKE:
        state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  // Sleep state, gates and wake interrupt
  always @(posedge CLK) begin
    if (SRST) begin
      state_reg <= ST_RUN;
      CPU_HALT <= 1'b0;
      CORE_GATE_EN <= 1'b1;
      WAKE_IRQ <= 1'b0;
    end else begin
      state_reg <= state_next;
      CPU_HALT <= state_next[1] | state_next[2];
      CORE_GATE_EN <= ~state_next[2];
      WAKE_IRQ <= state_reg[3];
    end
  end

  // ----------------------------------------
  // Bus and auxiliary clock dividers
  // ----------------------------------------
  // Tick every (divider + 1) cycles; a new divider applies at once to the running count
  // Ticks stop on the same edge as the core gate so none leaks into deep sleep
  always @(posedge CLK) begin
    if (SRST) begin
      bus_cnt_reg <= 4'h0;
      aux_cnt_reg <= 4'h0;
      BUS_CLK_TICK <= 1'b0;
      AUX_CLK_TICK <= 1'b0;
    end else if (state_next[2]) begin
      BUS_CLK_TICK <= 1'b0;
      AUX_CLK_TICK <= 1'b0;
    end else begin
      BUS_CLK_TICK <= (bus_cnt_reg == bus_div_reg);
      AUX_CLK_TICK <= (aux_cnt_reg == aux_div_reg);
      bus_cnt_reg <= (bus_cnt_reg >= bus_div_reg) ? 4'h0 : bus_cnt_reg + 4'h1;
      aux_cnt_reg <= (aux_cnt_reg >= aux_div_reg) ? 4'h0 : aux_cnt_reg + 4'h1;
    end
  end

endmodule
`default_nettype wire

// ==== tb/pll_ctl_properties.sv ====
// Concurrent checks on the ports of the PLL clock control block
`default_nettype none
module pll_ctl_properties (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Loop and mux state
  input wire logic PLL_RUN,
  input wire logic LOCK_DONE,
  input wire logic ROOT_CLK_EN,
  input wire logic MULTIPLIED_CLOCK_NET_EN,
  // Sleep state and derived ticks
  input wire logic CORE_GATE_EN,
  input wire logic CPU_HALT,
  input wire logic WAKE_IRQ,
  input wire logic BUS_CLK_TICK,
  input wire logic AUX_CLK_TICK,
  // Sleep and wake inputs
  input wire logic SLEEP_REQ,
  input wire logic IRQ_PENDING,
  input wire logic RTC_WAKE,
  input wire logic WDT_WAKE,
  input wire logic GPIO_WAKE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // Root path was off three cycles back, inside the switch gap
  sequence root_gap;
    $past(ROOT_CLK_EN, 3) == 1'h0;
  endsequence
  // Single interrupt pulse once clocks are back
  sequence wake_pulse;
    ##[1:2] WAKE_IRQ ##1 !WAKE_IRQ;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_NO_OVERLAP: assert property (!(ROOT_CLK_EN && MULTIPLIED_CLOCK_NET_EN))
    else $error("both core clock paths enabled");
  AST_SWITCH_GAP: assert property ($rose(MULTIPLIED_CLOCK_NET_EN) |-> root_gap)
    else $error("multiplied path enabled without gap");
  AST_LOCK_FIRST: assert property ($rose(MULTIPLIED_CLOCK_NET_EN) |-> LOCK_DONE && PLL_RUN)
    else $error("multiplied path enabled before lock");
  AST_STOP_NOW: assert property ($fell(PLL_RUN) |-> ##[0:2] !MULTIPLIED_CLOCK_NET_EN)
    else $error("multiplied path kept after disable");
  AST_HALT_CAUSE: assert property ($rose(CPU_HALT) |-> $past(SLEEP_REQ))
    else $error("halt without sleep request");
  AST_LIGHT_WAKE: assert property (CPU_HALT && CORE_GATE_EN && IRQ_PENDING |=> !CPU_HALT)
    else $error("light sleep ignored interrupt");
  AST_DEEP_QUIET: assert property (!CORE_GATE_EN |-> CPU_HALT && !BUS_CLK_TICK && !AUX_CLK_TICK)
    else $error("clocks running in deep sleep");
  AST_DEEP_HOLD: assert property (!CORE_GATE_EN && !RTC_WAKE && !WDT_WAKE && !GPIO_WAKE |=> !CORE_GATE_EN)
    else $error("deep sleep left without wake source");
  AST_WAKE_ORDER: assert property ($rose(CORE_GATE_EN) |-> wake_pulse)
    else $error("no wake interrupt after ungating");
  AST_IRQ_AFTER: assert property (WAKE_IRQ |-> CORE_GATE_EN && !CPU_HALT)
    else $error("wake interrupt before clocks restored");
endmodule
bind pll_clock_control_sleep pll_ctl_properties pll_ctl_properties_inst (
  .CLK(CLK),
  .SRST(SRST),
  .PLL_RUN(PLL_RUN),
  .LOCK_DONE(LOCK_DONE),
  .ROOT_CLK_EN(ROOT_CLK_EN),
  .MULTIPLIED_CLOCK_NET_EN(MULTIPLIED_CLOCK_NET_EN),
  .CORE_GATE_EN(CORE_GATE_EN),
  .CPU_HALT(CPU_HALT),
  .WAKE_IRQ(WAKE_IRQ),
  .BUS_CLK_TICK(BUS_CLK_TICK),
  .AUX_CLK_TICK(AUX_CLK_TICK),
  .SLEEP_REQ(SLEEP_REQ),
  .IRQ_PENDING(IRQ_PENDING),
  .RTC_WAKE(RTC_WAKE),
  .WDT_WAKE(WDT_WAKE),
  .GPIO_WAKE(GPIO_WAKE)
);
`default_nettype wire

// ==== tb/tb_pll_clock_control_sleep.sv ====
// Self-checking bench for the PLL clock control block
`default_nettype none
module tb_pll_clock_control_sleep;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'h0, SRST = 1'h1, HSEL = 1'h0, HWRITE = 1'h0, TRIMMED_REFERENCE_OSC = 1'h0;
  logic SLEEP_REQ, IRQ_PENDING, RTC_WAKE, WDT_WAKE, GPIO_WAKE, HREADY, HREADYOUT, HRESP, PLL_RUN;
  logic ROOT_CLK_EN, MULTIPLIED_CLOCK_NET_EN, CORE_GATE_EN, BUS_CLK_TICK, AUX_CLK_TICK, CPU_HALT, WAKE_IRQ;
  logic LOCK_DONE;
  logic [1:0] HTRANS = 2'h0, ph = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [4:0] st = 5'h00, PRE_DIVIDER, POST_DIVIDER;
  logic [7:0] HADDR = 8'h00;
  logic [8:0] LOOP_MULTIPLIER;
  logic [31:0] HWDATA = 32'h0, HRDATA, q;
  logic [31:0] dv [3] = '{32'h0500_5200, 32'h0100_3001, 32'h1f01_ff1f};
  logic [31:0] rt [3] = '{32'h0014_0150, 32'h0006_00c8, 32'h07fe_0804};
  int err_count = 0, compares = 0, nb, na;
  // ----------------------------------------
  // Clock, reference and wiring
  // ----------------------------------------
  always #2.5 CLK = ~CLK;
  // Reference level with one rise every four cycles
  always @(posedge CLK) begin
    ph <= ph + 2'h1;
    TRIMMED_REFERENCE_OSC <= ph[1];
  end
  assign HREADY = HREADYOUT;
  assign {GPIO_WAKE, WDT_WAKE, RTC_WAKE, IRQ_PENDING, SLEEP_REQ} = st;
  pll_clock_control_sleep pll_clock_control_sleep_inst (
    .CLK(CLK),
    .SRST(SRST),
    .HSEL(HSEL),
    .HADDR(HADDR),
    .HTRANS(HTRANS),
    .HWRITE(HWRITE),
    .HSIZE(HSIZE),
    .HWDATA(HWDATA),
    .HREADY(HREADY),
    .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT),
    .HRESP(HRESP),
    .TRIMMED_REFERENCE_OSC(TRIMMED_REFERENCE_OSC),
    .PLL_RUN(PLL_RUN),
    .PRE_DIVIDER(PRE_DIVIDER),
    .LOOP_MULTIPLIER(LOOP_MULTIPLIER),
    .POST_DIVIDER(POST_DIVIDER),
    .ROOT_CLK_EN(ROOT_CLK_EN),
    .MULTIPLIED_CLOCK_NET_EN(MULTIPLIED_CLOCK_NET_EN),
    .CORE_GATE_EN(CORE_GATE_EN),
    .BUS_CLK_TICK(BUS_CLK_TICK),
    .AUX_CLK_TICK(AUX_CLK_TICK),
    .SLEEP_REQ(SLEEP_REQ),
    .IRQ_PENDING(IRQ_PENDING),
    .RTC_WAKE(RTC_WAKE),
    .WDT_WAKE(WDT_WAKE),
    .GPIO_WAKE(GPIO_WAKE),
    .CPU_HALT(CPU_HALT),
    .WAKE_IRQ(WAKE_IRQ),
    .LOCK_DONE(LOCK_DONE)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out;
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic sg(input int s);
    case (s)
      0: return LOCK_DONE;
      1: return MULTIPLIED_CLOCK_NET_EN;
      2: return ROOT_CLK_EN;
      3: return WAKE_IRQ;
      default: return HREADY;
    endcase
  endfunction
  // Bounded wait for a flag, sampled at clock edges
  task automatic wt(input int s, input int lim);
    for (int n = 0; n < lim && sg(s) !== 1'h1; n++) @(posedge CLK);
    if (sg(s) !== 1'h1) begin
      err_count++;
      $display("[FAIL] %0t wait for flag %0d timed out", $time, s);
      close_out;
    end
  endtask
  // One single word transfer on the register bus
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    @(posedge CLK);
    wt(4, 20);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    wt(4, 20);
    q = HRDATA;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(q, exp);
  endtask
  // One-cycle pulse on a sleep or wake input
  task automatic pulse(input int i);
    @(posedge CLK);
    st[i] <= 1'h1;
    @(posedge CLK);
    st[i] <= 1'h0;
    @(posedge CLK);
  endtask
  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge CLK);
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    close_out;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge CLK);
    SRST <= 1'h0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0100_3000);
    rd(8'h10, 32'h0004_00c8);
    // Divider encodings, out-of-range included
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, 8'h04, dv[i]);
      rd(8'h04, dv[i]);
      rd(8'h10, rt[i]);
      chk({POST_DIVIDER, LOOP_MULTIPLIER, PRE_DIVIDER}, {dv[i][28:24], dv[i][16:8], dv[i][4:0]});
    end
    bus(1'h1, 8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0);
    chk(HRESP, 1'h0);
    chk(HREADYOUT, 1'h1);
    // Lock interval and switch to the multiplied clock
    // Pre /2 gives 2 MHz in, loop x100 and post 1 give 100 MHz out
    bus(1'h1, 8'h04, 32'h0100_6200);
    bus(1'h1, 8'h00, 32'h3);
    repeat (7990) @(posedge CLK);
    chk(LOCK_DONE, 1'h0);
    chk(MULTIPLIED_CLOCK_NET_EN, 1'h0);
    wt(0, 20);
    wt(1, 10);
    chk(ROOT_CLK_EN, 1'h0);
    rd(8'h0c, 32'hb);
    // Back to root, then stop the loop
    bus(1'h1, 8'h00, 32'h1);
    wt(2, 10);
    bus(1'h1, 8'h00, 32'h0);
    repeat (2) @(posedge CLK);
    chk({PLL_RUN, LOCK_DONE, MULTIPLIED_CLOCK_NET_EN}, 3'h0);
    // Bus and aux tick spacing
    bus(1'h1, 8'h08, 32'h103);
    repeat (8) @(posedge CLK);
    nb = 0;
    na = 0;
    repeat (40) begin
      @(posedge CLK);
      nb += BUS_CLK_TICK;
      na += AUX_CLK_TICK;
    end
    chk(nb, 10);
    chk(na, 20);
    // Ordinary sleep and interrupt wake
    pulse(0);
    chk({CPU_HALT, CORE_GATE_EN}, 2'h3);
    pulse(1);
    chk(CPU_HALT, 1'h0);
    // Deep sleep, interrupt ignored, each wake source
    bus(1'h1, 8'h00, 32'h4);
    for (int i = 2; i < 5; i++) begin
      pulse(0);
      chk({CPU_HALT, CORE_GATE_EN}, 2'h2);
      pulse(1);
      chk(CORE_GATE_EN, 1'h0);
      pulse(i);
      wt(3, 5);
      chk({CPU_HALT, CORE_GATE_EN}, 2'h1);
    end
    close_out;
  end
endmodule
`default_nettype wire
